/* design/pbg_regs.svh */
`ifndef PBG_REGS_SVH
`define PBG_REGS_SVH

// port geometry
`define PBG_MSB 7
`define PBG_W 8
`define PBG_ANA_HI 4
`define PBG_CHG_LO 4
`define PBG_CHG_HI 7

// bit positions inside the control registers
`define PBG_PULLUP_N_BIT 7
`define PBG_FLAG_BIT 0

// pin roles
`define PBG_SSP_CLK_PIN 1
`define PBG_SSP_DAT_PIN 0
`define PBG_XCVR_MINUS_PIN 2
`define PBG_XCVR_PLUS_PIN 3
`define PBG_ALT_CC_PIN 3
`define PBG_SPP_CS_PIN 4
`define PBG_PROG_PIN 5
`define PBG_PLAIN_PIN 6
`define PBG_PLAIN_IN_PIN 7
`define PBG_EXT_IRQ_HI 2
`define PBG_FAULT_PIN 0

// reset values
`define PBG_DIR_RST 8'hff
`define PBG_LAT_RST 8'h00
`define PBG_ZERO8 8'h00
`define PBG_ONES8 8'hff
`define PBG_PULLUP_N_RST 1'b1
`define PBG_FLAG_RST 1'b0
`define PBG_NIB_RST 4'h0
`define PBG_NIB_ZERO 4'h0
`define PBG_PAIR_RST 2'h0
`define PBG_TRI_RST 3'h0

`endif

/* design/pbg_pkg.sv */
package pbg_pkg;

  // one port-wide byte, analog group, change group, serial pair, irq trio
  typedef logic [7:0] pbg_byte_t;
  typedef logic [4:0] pbg_ana_t;
  typedef logic [3:0] pbg_nib_t;
  typedef logic [1:0] pbg_pair_t;
  typedef logic [2:0] pbg_tri_t;

  // which source drives a pin's output value
  typedef enum logic [1:0] {
    PBG_SRC_LATCH = 2'h0,
    PBG_SRC_SSP = 2'h1,
    PBG_SRC_USB = 2'h2,
    PBG_SRC_ALT = 2'h3
  } pbg_src_t;

endpackage

/* design/pbg_sync.sv */
`timescale 1ns/1ps
`default_nettype none
`include "pbg_regs.svh"

module pbg_sync (
  // clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // asynchronous pin levels and their synchronised copy
  input wire pbg_pkg::pbg_byte_t async_i,
  output pbg_pkg::pbg_byte_t sync_o
);

  pbg_pkg::pbg_byte_t meta_q;
  pbg_pkg::pbg_byte_t sync_q;

  // two-stage synchroniser, first stage read only by the second
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      meta_q <= `PBG_ZERO8;
      sync_q <= `PBG_ZERO8;
    end else begin
      meta_q <= async_i;
      sync_q <= meta_q;
    end
  end

  assign sync_o = sync_q;

endmodule
`default_nettype wire

/* design/pbg_change_det.sv */
`timescale 1ns/1ps
`default_nettype none
`include "pbg_regs.svh"

module pbg_change_det (
  // clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // monitored pins and which of them are compared
  input wire pbg_pkg::pbg_nib_t pins_i,
  input wire pbg_pkg::pbg_nib_t mon_en_i,
  input wire logic snap_load_i,
  // flag access
  input wire logic flag_wr_i,
  input wire logic flag_wdata_i,
  output logic flag_o,
  output logic wake_o
);

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  pbg_pkg::pbg_nib_t snap_q;
  pbg_pkg::pbg_nib_t mismatch;
  logic flag_q;
  logic wake_q;

  // compare only enabled inputs with the last snapshot
  assign mismatch = (pins_i ^ snap_q) & mon_en_i; // R10 R11

  // snapshot refreshed by every port read or counted write
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      snap_q <= `PBG_NIB_RST;
    end else if (snap_load_i) begin
      snap_q <= pins_i; // R11 R14
    end
  end

  // flag: a live mismatch wins over a software clear
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      flag_q <= `PBG_FLAG_RST;
    end else if (|mismatch) begin
      flag_q <= 1'b1; // R12 R15
    end else if (flag_wr_i) begin
      flag_q <= flag_wdata_i;
    end
  end

  // wake request follows any mismatch
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      wake_q <= 1'b0;
    end else begin
      wake_q <= |mismatch; // R13
    end
  end

  assign flag_o = flag_q;
  assign wake_o = wake_q;

  sequence read_then_clear_s;
    snap_load_i ##1
      (flag_wr_i && !flag_wdata_i && $stable(pins_i) && $stable(mon_en_i));
  endsequence

  flag_set_a: assert property (|mismatch |=> flag_q) // R12
    else $error("mismatch did not set the change flag");
  snap_take_a: assert property (snap_load_i |=> snap_q == $past(pins_i)) // R11
    else $error("snapshot did not capture the port value");
  read_clear_a: assert property (read_then_clear_s |=> !flag_q) // R15
    else $error("clear one cycle after a read was lost");
  wake_req_a: assert property (|mismatch |=> wake_o && flag_o) // R13
    else $error("mismatch did not raise wake");
  out_excl_a: assert property // R10
    ((mon_en_i == `PBG_NIB_ZERO && !flag_q && !flag_wr_i) |=> !flag_q)
    else $error("flag set with all change pins excluded");

endmodule
`default_nettype wire

/* design/pbg_port.sv */
// Function
// R1 - eight pins, each with own direction bit and output latch bit
// R2 - direction one floats the pin as input; zero drives latch value; serial output still drives pins 1,0 when their direction is one
// R3 - latch register addressable; its reads return latch, not pin levels
// R4 - one active-low bit seven of control two enables all pull-ups
// R5 - pull-up forced off on any pin set as output
// R6 - all pull-ups disabled after power-on reset
// R7 - low five pins reset analog, reading zero; upper three digital inputs
// R8 - nonvolatile config bit chooses digital instead of analog reset default
// R9 - config set gives analog default, cleared gives digital default
// R10 - change detect on pins seven to four, outputs excluded
// R11 - each monitored input compared to snapshot from last port read
// R12 - mismatches ORed into change flag, bit zero of main control
// R13 - change condition can wake the device from sleep
// R14 - port access ends mismatch, register move write excepted, then clear
// R15 - mismatch keeps setting flag; clear works one cycle after read
// R16 - software should avoid polling port while change detect used
// R17 - external transceiver data outputs on pins two, three when output
// R18 - pin four carries parallel port chip select when output
// R19 - serial module clock or data output overrides latch on pins 1,0
// R20 - analog selection kills digital input, leaves digital output alone; code masks port read and change-detect enables, peripherals take unmasked pins
// R21 - pins feed external irqs, fault input, alternate capture/compare
// R22 - low-voltage program config makes pin five program entry only
// R23 - port read returns synced pins; port write updates the latch
`timescale 1ns/1ps
`default_nettype none
`include "pbg_regs.svh"

module pbg_port (
  // clock and reset
  input wire logic CLK_I,
  input wire logic RSTN_I,
  // register write strobes and data
  input wire pbg_pkg::pbg_byte_t WDATA_I,
  input wire logic DIR_WR_I,
  input wire logic LAT_WR_I,
  input wire logic PORT_WR_I,
  input wire logic PORT_WR_MOVE_I,
  input wire logic PORT_RD_I,
  input wire logic IRQC2_WR_I,
  input wire logic IRQC_MAIN_WR_I,
  input wire logic ANALOG_WR_I,
  // register read data
  output pbg_pkg::pbg_byte_t PORT_RDATA_O,
  output pbg_pkg::pbg_byte_t LAT_RDATA_O,
  output pbg_pkg::pbg_byte_t DIR_RDATA_O,
  output logic PULLUP_ENABLE_N_O,
  output logic PIN_CHANGE_IRQ_FLAG_O,
  output logic CHANGE_WAKE_O,
  // nonvolatile configuration
  input wire logic LOW_PINS_ANALOG_DEFAULT_CFG_I,
  input wire logic LOW_VOLTAGE_PROGRAM_CFG_I,
  // pad side
  input wire pbg_pkg::pbg_byte_t PIN_I,
  output pbg_pkg::pbg_byte_t PIN_O,
  output pbg_pkg::pbg_byte_t PIN_OE_O,
  output pbg_pkg::pbg_byte_t PULLUP_EN_O,
  output pbg_pkg::pbg_ana_t ANALOG_EN_O,
  // synchronous serial module overrides on pins 1 and 0
  input wire pbg_pkg::pbg_pair_t SYNC_SERIAL_OE_I,
  input wire pbg_pkg::pbg_pair_t SYNC_SERIAL_DO_I,
  output pbg_pkg::pbg_pair_t SYNC_SERIAL_DI_O,
  // external transceiver outputs on pins 2 and 3
  input wire logic USB_EXT_XCVR_I,
  input wire logic XCVR_MINUS_DATA_OUT_I,
  input wire logic XCVR_PLUS_DATA_OUT_I,
  // parallel port chip select on pin 4
  input wire logic PARALLEL_PORT_CS_EN_I,
  input wire logic PARALLEL_PORT_CHIP_SELECT_I,
  // alternate capture / compare on pin 3
  input wire logic CAPTURE_COMPARE_2_OE_I,
  input wire logic CAPTURE_COMPARE_2_OUT_I,
  output logic CAPTURE_COMPARE_2_IN_O,
  // inputs handed to other peripherals
  output pbg_pkg::pbg_tri_t EXT_IRQ_IN_O,
  output logic PWM_FAULT_IN_O,
  output logic SINGLE_SUPPLY_PROGRAM_ENTRY_O
);

  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RSTN_I);

  // digital input mask: analog pins, and the program pin under low-voltage program config, read zero
  function automatic pbg_pkg::pbg_byte_t dig_mask(
    input pbg_pkg::pbg_ana_t ana,
    input logic prog
  );
    pbg_pkg::pbg_byte_t m;
    m = `PBG_ONES8;
    m[`PBG_ANA_HI:0] = ~ana; // R20
    if (prog) begin
      m[`PBG_PROG_PIN] = 1'b0; // R22
    end
    return m;
  endfunction

  // output value for one pin from its selected source
  function automatic logic pick_val(
    input pbg_pkg::pbg_src_t src,
    input logic lat,
    input logic ssp,
    input logic usb,
    input logic alt
  );
    case (src)
      pbg_pkg::PBG_SRC_LATCH: pick_val = lat;
      pbg_pkg::PBG_SRC_SSP: pick_val = ssp;
      pbg_pkg::PBG_SRC_USB: pick_val = usb;
      pbg_pkg::PBG_SRC_ALT: pick_val = alt;
      default: pick_val = lat;
    endcase
  endfunction

  pbg_pkg::pbg_byte_t pin_sync;
  pbg_pkg::pbg_byte_t direction_reg_q;
  pbg_pkg::pbg_byte_t output_latch_reg_q;
  pbg_pkg::pbg_byte_t pin_value_reg_q;
  pbg_pkg::pbg_ana_t analog_q;
  logic pullup_enable_n_q;
  pbg_pkg::pbg_byte_t mask;
  pbg_pkg::pbg_byte_t ssp_req;
  pbg_pkg::pbg_byte_t ssp_val;
  pbg_pkg::pbg_byte_t usb_req;
  pbg_pkg::pbg_byte_t usb_val;
  pbg_pkg::pbg_byte_t alt_req;
  pbg_pkg::pbg_byte_t alt_val;
  pbg_pkg::pbg_byte_t drive_d;
  pbg_pkg::pbg_byte_t oe_d;
  pbg_pkg::pbg_byte_t pullup_d;
  pbg_pkg::pbg_byte_t pin_o_q;
  pbg_pkg::pbg_byte_t pin_oe_q;
  pbg_pkg::pbg_byte_t pullup_q;
  pbg_pkg::pbg_pair_t ssp_di_q;
  pbg_pkg::pbg_tri_t ext_irq_q;
  logic fault_q;
  logic cc_in_q;
  logic prog_entry_q;
  logic snap_load;

  // pad inputs pass two flops before any logic
  pbg_sync u_sync (
    .clk_i(CLK_I),
    .rstn_i(RSTN_I),
    .async_i(PIN_I),
    .sync_o(pin_sync)
  );

  assign mask = dig_mask(analog_q, LOW_VOLTAGE_PROGRAM_CFG_I);

  // direction register, all inputs after reset
  always_ff @(posedge CLK_I) begin
    if (!RSTN_I) begin
      direction_reg_q <= `PBG_DIR_RST; // R1 R7
    end else if (DIR_WR_I) begin
      direction_reg_q <= WDATA_I;
    end
  end

  // output latch, written through latch or port address
  always_ff @(posedge CLK_I) begin
    if (!RSTN_I) begin
      output_latch_reg_q <= `PBG_LAT_RST;
    end else if (LAT_WR_I || PORT_WR_I) begin
      output_latch_reg_q <= WDATA_I; // R1 R3 R23
    end
  end

  // shared active-low pull-up control, pull-ups off after reset
  always_ff @(posedge CLK_I) begin
    if (!RSTN_I) begin
      pullup_enable_n_q <= `PBG_PULLUP_N_RST; // R6
    end else if (IRQC2_WR_I) begin
      pullup_enable_n_q <= WDATA_I[`PBG_PULLUP_N_BIT]; // R4
    end
  end

  // analog selection of the low pins, reset default from config
  always_ff @(posedge CLK_I) begin
    if (!RSTN_I) begin
      analog_q <= {5{LOW_PINS_ANALOG_DEFAULT_CFG_I}}; // R7 R8 R9
    end else if (ANALOG_WR_I) begin
      analog_q <= WDATA_I[`PBG_ANA_HI:0];
    end
  end

  // port read value: synced pins with disabled inputs at zero
  always_ff @(posedge CLK_I) begin
    if (!RSTN_I) begin
      pin_value_reg_q <= `PBG_ZERO8;
    end else begin
      pin_value_reg_q <= pin_sync & mask; // R7 R20 R23
    end
  end

  // peripheral override requests per pin
  always_comb begin
    ssp_req = `PBG_ZERO8;
    ssp_val = `PBG_ZERO8;
    usb_req = `PBG_ZERO8;
    usb_val = `PBG_ZERO8;
    alt_req = `PBG_ZERO8;
    alt_val = `PBG_ZERO8;
    ssp_req[`PBG_SSP_DAT_PIN] = SYNC_SERIAL_OE_I[0]; // R19
    ssp_req[`PBG_SSP_CLK_PIN] = SYNC_SERIAL_OE_I[1];
    ssp_val[`PBG_SSP_DAT_PIN] = SYNC_SERIAL_DO_I[0];
    ssp_val[`PBG_SSP_CLK_PIN] = SYNC_SERIAL_DO_I[1];
    usb_req[`PBG_XCVR_MINUS_PIN] = USB_EXT_XCVR_I &&
      !direction_reg_q[`PBG_XCVR_MINUS_PIN]; // R17
    usb_req[`PBG_XCVR_PLUS_PIN] = USB_EXT_XCVR_I &&
      !direction_reg_q[`PBG_XCVR_PLUS_PIN];
    usb_val[`PBG_XCVR_MINUS_PIN] = XCVR_MINUS_DATA_OUT_I;
    usb_val[`PBG_XCVR_PLUS_PIN] = XCVR_PLUS_DATA_OUT_I;
    alt_req[`PBG_ALT_CC_PIN] = CAPTURE_COMPARE_2_OE_I &&
      !direction_reg_q[`PBG_ALT_CC_PIN]; // R21
    alt_val[`PBG_ALT_CC_PIN] = CAPTURE_COMPARE_2_OUT_I;
    alt_req[`PBG_SPP_CS_PIN] = PARALLEL_PORT_CS_EN_I &&
      !direction_reg_q[`PBG_SPP_CS_PIN]; // R18
    alt_val[`PBG_SPP_CS_PIN] = PARALLEL_PORT_CHIP_SELECT_I;
  end

  // per-pin source select and output value
  for (genvar i = 0; i < `PBG_W; i++) begin : g_pin
    pbg_pkg::pbg_src_t src;
    always_comb begin
      if (ssp_req[i]) begin
        src = pbg_pkg::PBG_SRC_SSP; // R19
      end else if (usb_req[i]) begin
        src = pbg_pkg::PBG_SRC_USB;
      end else if (alt_req[i]) begin
        src = pbg_pkg::PBG_SRC_ALT;
      end else begin
        src = pbg_pkg::PBG_SRC_LATCH;
      end
    end
    assign drive_d[i] = pick_val(src, output_latch_reg_q[i],
                                 ssp_val[i], usb_val[i], alt_val[i]); // R2
  end

  // driver enable and pull-up enable
  always_comb begin
    oe_d = ~direction_reg_q | ssp_req; // R2 R19 R20
    pullup_d = direction_reg_q & {`PBG_W{!pullup_enable_n_q}}; // R4 R5
    if (LOW_VOLTAGE_PROGRAM_CFG_I) begin
      oe_d[`PBG_PROG_PIN] = 1'b0; // R22
      pullup_d[`PBG_PROG_PIN] = 1'b0;
    end
  end

  // registered pad controls
  always_ff @(posedge CLK_I) begin
    if (!RSTN_I) begin
      pin_o_q <= `PBG_ZERO8;
      pin_oe_q <= `PBG_ZERO8;
      pullup_q <= `PBG_ZERO8; // R6
    end else begin
      pin_o_q <= drive_d;
      pin_oe_q <= oe_d;
      pullup_q <= pullup_d;
    end
  end

  // pin levels handed to other peripherals
  always_ff @(posedge CLK_I) begin
    if (!RSTN_I) begin
      ssp_di_q <= `PBG_PAIR_RST;
      ext_irq_q <= `PBG_TRI_RST;
      fault_q <= 1'b0;
      cc_in_q <= 1'b0;
      prog_entry_q <= 1'b0;
    end else begin
      ssp_di_q <= {pin_sync[`PBG_SSP_CLK_PIN], pin_sync[`PBG_SSP_DAT_PIN]};
      ext_irq_q <= pin_sync[`PBG_EXT_IRQ_HI:0]; // R21
      fault_q <= pin_sync[`PBG_FAULT_PIN];
      cc_in_q <= pin_sync[`PBG_ALT_CC_PIN];
      prog_entry_q <= LOW_VOLTAGE_PROGRAM_CFG_I &&
        pin_sync[`PBG_PROG_PIN]; // R22
    end
  end

  // snapshot refresh: any read, any write but a register move
  assign snap_load = PORT_RD_I || (PORT_WR_I && !PORT_WR_MOVE_I); // R14

  pbg_change_det u_chg (
    .clk_i(CLK_I),
    .rstn_i(RSTN_I),
    .pins_i(pin_value_reg_q[`PBG_CHG_HI:`PBG_CHG_LO]), // R10
    .mon_en_i(direction_reg_q[`PBG_CHG_HI:`PBG_CHG_LO] &
              mask[`PBG_CHG_HI:`PBG_CHG_LO]), // R10
    .snap_load_i(snap_load),
    .flag_wr_i(IRQC_MAIN_WR_I),
    .flag_wdata_i(WDATA_I[`PBG_FLAG_BIT]),
    .flag_o(PIN_CHANGE_IRQ_FLAG_O),
    .wake_o(CHANGE_WAKE_O)
  );

  // outputs
  assign PORT_RDATA_O = pin_value_reg_q;
  assign LAT_RDATA_O = output_latch_reg_q;
  assign DIR_RDATA_O = direction_reg_q;
  assign PULLUP_ENABLE_N_O = pullup_enable_n_q;
  assign PIN_O = pin_o_q;
  assign PIN_OE_O = pin_oe_q;
  assign PULLUP_EN_O = pullup_q;
  assign ANALOG_EN_O = analog_q;
  assign SYNC_SERIAL_DI_O = ssp_di_q;
  assign EXT_IRQ_IN_O = ext_irq_q;
  assign PWM_FAULT_IN_O = fault_q;
  assign CAPTURE_COMPARE_2_IN_O = cc_in_q;
  assign SINGLE_SUPPLY_PROGRAM_ENTRY_O = prog_entry_q;

  sequence latch_write_s;
    LAT_WR_I && !PORT_WR_I;
  endsequence

  sequence port_write_s;
    PORT_WR_I && !LAT_WR_I;
  endsequence

  out_drive_a: assert property // R2
    (!direction_reg_q[`PBG_PLAIN_PIN] |=> PIN_OE_O[`PBG_PLAIN_PIN] &&
     PIN_O[`PBG_PLAIN_PIN] == $past(output_latch_reg_q[`PBG_PLAIN_PIN]))
    else $error("output pin does not drive the latch value");
  in_float_a: assert property // R2
    (direction_reg_q[`PBG_PLAIN_IN_PIN] |=> !PIN_OE_O[`PBG_PLAIN_IN_PIN])
    else $error("input pin is being driven");
  latch_write_a: assert property // R3
    (latch_write_s |=> LAT_RDATA_O == $past(WDATA_I))
    else $error("latch write not stored");
  port_write_a: assert property // R23
    (port_write_s |=> LAT_RDATA_O == $past(WDATA_I))
    else $error("port write did not update the latch");
  pullup_out_a: assert property // R5
    (1'b1 |=> (PULLUP_EN_O & ~$past(direction_reg_q)) == `PBG_ZERO8)
    else $error("pull-up on an output pin");
  pullup_on_a: assert property // R4
    (!pullup_enable_n_q && direction_reg_q[`PBG_PLAIN_IN_PIN]
     |=> PULLUP_EN_O[`PBG_PLAIN_IN_PIN])
    else $error("pull-up not enabled on an input pin");
  reset_pull_a: assert property // R6
    ($rose(RSTN_I) |-> PULLUP_EN_O == `PBG_ZERO8 && PULLUP_ENABLE_N_O)
    else $error("pull-ups not disabled after reset");
  reset_ana_a: assert property // R9
    ($rose(RSTN_I) |-> ANALOG_EN_O == {5{LOW_PINS_ANALOG_DEFAULT_CFG_I}})
    else $error("analog default does not follow the config bit");
  ana_read_a: assert property // R7
    (analog_q[0] && !ANALOG_WR_I |=> PORT_RDATA_O[0] == 1'b0)
    else $error("analog pin reads nonzero");
  ssp_prio_a: assert property // R19
    (SYNC_SERIAL_OE_I[0] |=> PIN_OE_O[`PBG_SSP_DAT_PIN] &&
     PIN_O[`PBG_SSP_DAT_PIN] == $past(SYNC_SERIAL_DO_I[0]))
    else $error("serial output lost priority");
  prog_pin_a: assert property // R22
    (LOW_VOLTAGE_PROGRAM_CFG_I |=> !PIN_OE_O[`PBG_PROG_PIN] &&
     !PULLUP_EN_O[`PBG_PROG_PIN])
    else $error("program entry pin still has other functions");
  xcvr_out_a: assert property // R17
    (USB_EXT_XCVR_I && !direction_reg_q[`PBG_XCVR_PLUS_PIN] &&
     !SYNC_SERIAL_OE_I[1] |=> PIN_O[`PBG_XCVR_PLUS_PIN] ==
     $past(XCVR_PLUS_DATA_OUT_I))
    else $error("transceiver data not on its pin");

endmodule
`default_nettype wire

/* dv/pbg_ext_circuit.sv */
`timescale 1ns/1ps
`default_nettype none

module pbg_ext_circuit (
  // clock
  input wire logic clk_i,
  // device pad controls
  input wire pbg_pkg::pbg_byte_t pin_o_i,
  input wire pbg_pkg::pbg_byte_t pin_oe_i,
  input wire pbg_pkg::pbg_byte_t pullup_en_i,
  // external drivers on the board
  input wire pbg_pkg::pbg_byte_t drv_en_i,
  input wire pbg_pkg::pbg_byte_t drv_val_i,
  // resolved pad levels
  output pbg_pkg::pbg_byte_t pin_lvl_o
);
  pbg_pkg::pbg_byte_t float_q = 8'h5a;

  // an undriven pad without pull-up wanders every cycle
  always_ff @(posedge clk_i) begin
    float_q <= ~float_q;
  end

  // device driver first, then board driver, then pull-up
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (pin_oe_i[i]) begin
        pin_lvl_o[i] = pin_o_i[i];
      end else if (drv_en_i[i]) begin
        pin_lvl_o[i] = drv_val_i[i];
      end else if (pullup_en_i[i]) begin
        pin_lvl_o[i] = 1'b1;
      end else begin
        pin_lvl_o[i] = float_q[i];
      end
    end
  end
endmodule

`default_nettype wire

/* dv/pbg_port_tb.sv */
`timescale 1ns/1ps
`default_nettype none

module pbg_port_tb;
  localparam int S_DIR = 0;
  localparam int S_LAT = 1;
  localparam int S_PORT = 2;
  localparam int S_RD = 3;
  localparam int S_PU = 4;
  localparam int S_FLG = 5;
  localparam int S_ANA = 6;
  logic clk, rstn, dir_wr, lat_wr, port_wr, move, port_rd, irqc2_wr, irqc_wr;
  logic ana_wr, ana_cfg, lvp_cfg, usb_ext, xm, xp, cs_en, cs, cc_oe, cc_out;
  logic pun, flag, wake, cc_in, fault, prog;
  pbg_pkg::pbg_byte_t wdata, rd_d, lat_rd, dir_rd, pin_o, pin_oe, pu_en;
  pbg_pkg::pbg_byte_t pin_lvl, drv_en, drv_val;
  pbg_pkg::pbg_ana_t ana_en;
  pbg_pkg::pbg_pair_t ssp_oe, ssp_do, ssp_di;
  pbg_pkg::pbg_tri_t ext_irq;
  int fail_count, checked, m_dir, m_lat, m_ana;
  logic [15:0] rnd_q = 16'h5123;

  pbg_port u_dut (.CLK_I(clk), .RSTN_I(rstn), .WDATA_I(wdata),
    .DIR_WR_I(dir_wr), .LAT_WR_I(lat_wr), .PORT_WR_I(port_wr),
    .PORT_WR_MOVE_I(move), .PORT_RD_I(port_rd), .IRQC2_WR_I(irqc2_wr),
    .IRQC_MAIN_WR_I(irqc_wr), .ANALOG_WR_I(ana_wr), .PORT_RDATA_O(rd_d),
    .LAT_RDATA_O(lat_rd), .DIR_RDATA_O(dir_rd), .PULLUP_ENABLE_N_O(pun),
    .PIN_CHANGE_IRQ_FLAG_O(flag), .CHANGE_WAKE_O(wake),
    .LOW_PINS_ANALOG_DEFAULT_CFG_I(ana_cfg),
    .LOW_VOLTAGE_PROGRAM_CFG_I(lvp_cfg), .PIN_I(pin_lvl), .PIN_O(pin_o),
    .PIN_OE_O(pin_oe), .PULLUP_EN_O(pu_en), .ANALOG_EN_O(ana_en),
    .SYNC_SERIAL_OE_I(ssp_oe), .SYNC_SERIAL_DO_I(ssp_do),
    .SYNC_SERIAL_DI_O(ssp_di), .USB_EXT_XCVR_I(usb_ext),
    .XCVR_MINUS_DATA_OUT_I(xm), .XCVR_PLUS_DATA_OUT_I(xp),
    .PARALLEL_PORT_CS_EN_I(cs_en), .PARALLEL_PORT_CHIP_SELECT_I(cs),
    .CAPTURE_COMPARE_2_OE_I(cc_oe), .CAPTURE_COMPARE_2_OUT_I(cc_out),
    .CAPTURE_COMPARE_2_IN_O(cc_in), .EXT_IRQ_IN_O(ext_irq),
    .PWM_FAULT_IN_O(fault), .SINGLE_SUPPLY_PROGRAM_ENTRY_O(prog));

  pbg_ext_circuit u_ext (.clk_i(clk), .pin_o_i(pin_o), .pin_oe_i(pin_oe),
    .pullup_en_i(pu_en), .drv_en_i(drv_en), .drv_val_i(drv_val),
    .pin_lvl_o(pin_lvl));

  // free-running clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  function automatic pbg_pkg::pbg_byte_t rnd();
    rnd_q = {rnd_q[14:0], rnd_q[15] ^ rnd_q[13] ^ rnd_q[12] ^ rnd_q[10]};
    return rnd_q[7:0];
  endfunction

  // pad level: board value on inputs, latch on outputs
  function automatic pbg_pkg::pbg_byte_t lvl_exp();
    return (m_dir[7:0] & drv_val) | (~m_dir[7:0] & m_lat[7:0]);
  endfunction

  // port read value with analog and program masking
  function automatic pbg_pkg::pbg_byte_t exp_rd();
    pbg_pkg::pbg_byte_t l;
    l = lvl_exp();
    l[4:0] = l[4:0] & ~m_ana[4:0];
    if (lvp_cfg) begin
      l[5] = 1'b0;
    end
    return l;
  endfunction

  task automatic give_verdict();
    $display("checked=%0d fail_count=%0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk8(input pbg_pkg::pbg_byte_t got, exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask

  // one-cycle write or read strobe, model updated alongside
  task automatic strobe(input int sel, input pbg_pkg::pbg_byte_t d);
    wdata = d;
    case (sel)
      S_DIR: begin
        dir_wr = 1'b1;
        m_dir = int'(d);
        drv_en = d;
      end
      S_LAT: begin
        lat_wr = 1'b1;
        m_lat = int'(d);
      end
      S_PORT: begin
        port_wr = 1'b1;
        m_lat = int'(d);
      end
      S_RD: port_rd = 1'b1;
      S_PU: irqc2_wr = 1'b1;
      S_FLG: irqc_wr = 1'b1;
      default: begin
        ana_wr = 1'b1;
        m_ana = int'(d[4:0]);
      end
    endcase
    @(negedge clk);
    {dir_wr, lat_wr, port_wr, port_rd, irqc2_wr, irqc_wr, ana_wr} = 7'h00;
    @(negedge clk);
  endtask

  // bounded wait for the change flag; polling the port is avoided
  task automatic wait_flag();
    int n;
    n = 0;
    while (flag !== 1'b1 && n < 10) begin
      @(negedge clk);
      n++;
    end
    if (flag !== 1'b1) begin
      fail_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, flag, 1'b1);
      give_verdict();
    end
  endtask

  // main sequence
  initial begin
    pbg_pkg::pbg_byte_t r;
    {dir_wr, lat_wr, port_wr, move, port_rd, irqc2_wr, irqc_wr} = 7'h00;
    {ana_wr, usb_ext, xm, xp, cs_en, cs, cc_oe, cc_out, lvp_cfg} = 9'h000;
    {ssp_oe, ssp_do} = 4'h0;
    rstn = 1'b0;
    ana_cfg = 1'b1;
    wdata = 8'h00;
    drv_en = 8'hff;
    drv_val = rnd();
    fail_count = 0;
    checked = 0;
    m_dir = 255;
    m_lat = 0;
    m_ana = 31;
    tick(3);
    chk8(dir_rd, 8'hff);
    chk8(lat_rd, 8'h00);
    chk8(pu_en, 8'h00);
    chk1(pun, 1'b1);
    chk8({3'h0, ana_en}, 8'h1f);
    chk8(pin_oe, 8'h00);
    rstn = 1'b1;
    tick(6);
    chk8(rd_d, exp_rd());
    // latch writes through both addresses
    for (int i = 0; i < 3; i++) begin
      strobe(S_LAT, rnd());
      chk8(lat_rd, m_lat[7:0]);
      move = i[0];
      strobe(S_PORT, rnd());
      move = 1'b0;
      chk8(lat_rd, m_lat[7:0]);
    end
    strobe(S_ANA, 8'h15);
    chk8({3'h0, ana_en}, m_ana[7:0]);
    // random direction: pads, pull-ups, reads, peripheral inputs
    for (int i = 0; i < 4; i++) begin
      strobe(S_DIR, rnd());
      strobe(S_PU, {~i[0], 7'h00});
      drv_val = rnd();
      tick(6);
      chk8(dir_rd, m_dir[7:0]);
      chk8(pin_oe, ~m_dir[7:0]);
      chk8(pin_o & ~m_dir[7:0], m_lat[7:0] & ~m_dir[7:0]);
      chk1(pun, ~i[0]);
      chk8(pu_en, i[0] ? m_dir[7:0] : 8'h00);
      chk8(rd_d, exp_rd());
      r = lvl_exp();
      chk8({3'h0, cc_in, fault, ext_irq}, {3'h0, r[3], r[0], r[2:0]});
      chk8({6'h00, ssp_di}, {6'h00, r[1:0]});
    end
    // peripheral overrides on output pins, then serial data override on an input pin
    strobe(S_DIR, 8'h00);
    strobe(S_LAT, 8'h00);
    {ssp_oe, ssp_do, usb_ext, xm, xp, cs_en, cs} = 9'h1df;
    tick(3);
    chk8(pin_o, 8'h1e);
    {ssp_oe, usb_ext, cs_en, cc_oe, cc_out} = 6'h03;
    tick(3);
    chk8(pin_o, 8'h08);
    strobe(S_DIR, 8'hff);
    {ssp_oe, ssp_do, usb_ext, cc_oe} = 6'h16;
    tick(3);
    chk8(pin_oe, 8'h01);
    chk8(pin_o & 8'h01, 8'h01);
    {ssp_oe, usb_ext} = 3'h0;
    // change detect: settle, refresh snapshot, clear
    drv_val = 8'h00;
    tick(6);
    strobe(S_RD, 8'h00);
    strobe(S_FLG, 8'h00);
    chk1(flag, 1'b0);
    drv_val = 8'h80;
    wait_flag();
    chk1(wake, 1'b1);
    // clear in the same cycle as the read is lost
    wdata = 8'h00;
    port_rd = 1'b1;
    irqc_wr = 1'b1;
    @(negedge clk);
    port_rd = 1'b0;
    chk1(flag, 1'b1);
    // clear held one more cycle: now one cycle after the read, it works
    @(negedge clk);
    chk1(flag, 1'b0);
    strobe(S_FLG, 8'h00);
    chk1(flag, 1'b0);
    chk1(wake, 1'b0);
    // a register move write does not end the mismatch
    drv_val = 8'hc0;
    wait_flag();
    move = 1'b1;
    strobe(S_PORT, 8'h00);
    move = 1'b0;
    strobe(S_FLG, 8'h00);
    chk1(flag, 1'b1);
    strobe(S_PORT, 8'h00);
    strobe(S_FLG, 8'h00);
    chk1(flag, 1'b0);
    // an output pin is left out of the comparison
    strobe(S_DIR, 8'h7f);
    tick(8);
    chk1(flag, 1'b0);
    // second reset with digital default and program entry
    rstn = 1'b0;
    ana_cfg = 1'b0;
    lvp_cfg = 1'b1;
    drv_en = 8'hff;
    tick(3);
    chk8({3'h0, ana_en}, 8'h00);
    rstn = 1'b1;
    m_dir = 255;
    m_lat = 0;
    m_ana = 0;
    drv_val = rnd() | 8'h20;
    tick(6);
    chk8(rd_d, exp_rd());
    chk1(prog, 1'b1);
    give_verdict();
  end
endmodule

`default_nettype wire
